// ==== lvs_supervisor.sv ====
// Purpose: Line voltage supervisor: zero cross, crossing timeout,
//          line period, sag detection and low-supply state.
// Assumes: Register accesses come decoded from the serial port logic;
//          samples are line low-pass outputs on the core clock.
// Notes:   The supply-low level is asynchronous and is synchronised.
// How it works
// - Zero-cross output goes high on positive crossing, low on negative.
// - Crossings are judged on low-pass filtered samples, so edges lag.
// - Zero-cross flag sets on both directions, holds until clearing read.
// - Interrupt pin goes low for a set flag only when enabled.
// - Clearing status read returns flags and interrupt pin to idle unless a flag sets in that cycle.
// - Twelve-bit timeout counter decrements once every 128 clocks.
// - Each detected crossing reloads the timeout counter from software value.
// - Timeout reload value is 0xFFF after reset.
// - Timeout reaching zero drives sag pin low unless sag pin disabled.
// - Timeout always sets its flag; interrupt only if enabled.
// - Host reads and writes timeout reload at address 0x1D.
// - Sixteen-bit period register updates each line cycle, top bit zero.
// - Period counts eight-clock units per line cycle.
// - Period is filtered to hold within one LSB after settling.
// - Low analog supply puts the device in an inactive state.
// - Sag pin goes low one clock after the inactive state starts and stays low while it lasts.
// - Sag cycle count is one more than cycles needed; 0 and 1 invalid.
// - Sag pin falls at end of last full below-threshold cycle.
// - Detected sag sets sag flag and interrupts when enabled.
// - Sag pin returns high once the signal reaches the threshold.
// - Threshold compared with top byte of doubled absolute sample.
// - Threshold 0x00 or 0x01 means a zero detection level.
`timescale 1ns/100ps
`default_nettype none
`include "lvs_regs.svh"

module lvs_supervisor #(
  parameter int SETTLE_CLKS = `LVS_SETTLE_CLKS   // Period settling time
) (
  input wire logic core_clk_i,                 // Core clock, 25 MHz
  input wire logic sys_rst_i,                  // Synchronous reset
  input wire logic samp_valid_i,               // Filtered sample strobe
  input wire lvs_pkg::lvs_sample_t samp_i,     // Line low-pass output
  input wire logic supply_low_i,               // Analog supply below trigger
  input wire logic [5:0] reg_addr_i,           // Register address
  input wire logic reg_wr_i,                   // Write strobe
  input wire logic reg_rd_i,                   // Read strobe
  input wire logic [15:0] reg_wdata_i,         // Write data
  output logic [15:0] reg_rdata_o,             // Read data
  output logic reg_rvalid_o,                   // Read data valid pulse
  output logic zero_cross_out_o,               // Zero-cross output
  output logic sag_n_o,                        // Sag pin, active low
  output logic irq_n_o,                        // Interrupt pin, active low
  output logic inactive_o                      // Low-supply inactive state
);

  // Magnitude of a sample, top byte after doubling
  function automatic logic [7:0] mag_byte(input logic [15:0] s);
    logic [15:0] a;
    a = s[15] ? 16'(-s) : s;
    mag_byte = a[14:7];
  endfunction

  // Register storage
  logic [11:0] to_reload_ff;
  logic [7:0] sag_cyc_ff;
  logic [7:0] sag_lvl_ff;
  logic [15:0] mode_ff;
  logic [15:0] irq_en_ff;
  logic [15:0] status_ff;
  logic [15:0] reg_rdata_ff;
  logic reg_rvalid_ff;

  // Block state
  logic sup_meta_ff;
  logic sup_sync_ff;
  logic [6:0] pre_cnt_ff;
  logic [11:0] to_cnt_ff;
  logic to_sag_ff;
  logic [2:0] unit_div_ff;
  logic [15:0] unit_cnt_ff;
  logic [19:0] per_acc_ff;
  logic per_seeded_ff;
  logic per_armed_ff;
  logic [31:0] settle_cnt_ff;
  logic settled_ff;
  lvs_pkg::lvs_sag_e sag_state_ff;
  logic [7:0] below_cycles_ff;
  logic above_seen_ff;
  logic sag_n_ff;
  logic irq_n_ff;

  // Combinational terms
  logic zc_rise;
  logic zc_fall;
  logic zc_any;
  logic zc_level;
  logic to_tick;
  logic to_hit;
  logic sag_dis;
  logic [7:0] lvl_eff;
  logic samp_below;
  logic sag_event;
  logic clr_read;
  logic [15:0] set_flags;
  logic [19:0] meas_acc;
  logic [19:0] nxt_per_acc;

  // Crossing detection on filtered samples
  lvs_zc_detect u_zc (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .samp_valid_i(samp_valid_i),
    .samp_i(samp_i),
    .rise_o(zc_rise),
    .fall_o(zc_fall),
    .level_o(zc_level)
  );

  // Edges lag the analog crossing by the filter delay
  assign zero_cross_out_o = zc_level;
  assign zc_any = zc_rise || zc_fall;
  assign sag_dis = mode_ff[`LVS_MODE_SAG_DIS];
  assign clr_read = reg_rd_i && (reg_addr_i == `LVS_OFS_STATUS_CLR);

  // Supply monitor level crosses in from the analog side
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sup_meta_ff <= 1'b0;
      sup_sync_ff <= 1'b0;
    end else begin
      sup_meta_ff <= supply_low_i;
      sup_sync_ff <= sup_meta_ff;
    end
  end

  assign inactive_o = sup_sync_ff;

  // Register writes
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      to_reload_ff <= `LVS_RST_TIMEOUT;
      sag_cyc_ff <= `LVS_RST_SAG_CYC;
      sag_lvl_ff <= `LVS_RST_SAG_LVL;
      mode_ff <= `LVS_RST_MODE;
      irq_en_ff <= `LVS_RST_IRQ_EN;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `LVS_OFS_TIMEOUT) begin
        to_reload_ff <= reg_wdata_i[11:0];
      end else if (reg_addr_i == `LVS_OFS_SAG_CYC) begin
        sag_cyc_ff <= reg_wdata_i[7:0];
      end else if (reg_addr_i == `LVS_OFS_SAG_LVL) begin
        sag_lvl_ff <= reg_wdata_i[7:0];
      end else if (reg_addr_i == `LVS_OFS_MODE) begin
        mode_ff <= {1'b0, reg_wdata_i[14:0]};
      end else if (reg_addr_i == `LVS_OFS_IRQ_EN) begin
        irq_en_ff <= reg_wdata_i & `LVS_FLAG_MASK;
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_ff <= 16'h0000;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd_i;
      if (reg_rd_i) begin
        if (reg_addr_i == `LVS_OFS_TIMEOUT) begin
          reg_rdata_ff <= {4'h0, to_reload_ff};
        end else if (reg_addr_i == `LVS_OFS_PERIOD) begin
          reg_rdata_ff <= per_acc_ff[19:4] & `LVS_PERIOD_MAX;
        end else if (reg_addr_i == `LVS_OFS_SAG_CYC) begin
          reg_rdata_ff <= {8'h00, sag_cyc_ff};
        end else if (reg_addr_i == `LVS_OFS_SAG_LVL) begin
          reg_rdata_ff <= {8'h00, sag_lvl_ff};
        end else if (reg_addr_i == `LVS_OFS_MODE) begin
          reg_rdata_ff <= {settled_ff, mode_ff[14:0]};
        end else if (reg_addr_i == `LVS_OFS_IRQ_EN) begin
          reg_rdata_ff <= irq_en_ff;
        end else if (reg_addr_i == `LVS_OFS_STATUS || clr_read) begin
          reg_rdata_ff <= status_ff;
        end else begin
          reg_rdata_ff <= 16'h0000;
        end
      end
    end
  end

  assign reg_rdata_o = reg_rdata_ff;
  assign reg_rvalid_o = reg_rvalid_ff;

  // Timeout prescaler, one tick per 128 clocks
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pre_cnt_ff <= 7'h00;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 7'h01;
    end
  end

  assign to_tick = (pre_cnt_ff == 7'(`LVS_TO_TICK_CLKS - 1));
  assign to_hit = to_tick && !zc_any && (to_cnt_ff == 12'h001);

  // Timeout counter; parks at zero until the next crossing
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      to_cnt_ff <= `LVS_RST_TIMEOUT;
    end else if (zc_any) begin
      to_cnt_ff <= to_reload_ff;
    end else if (to_tick && to_cnt_ff != 12'h000) begin
      to_cnt_ff <= to_cnt_ff - 12'h001;
    end
  end

  // Missing crossings pull the sag pin until a crossing returns
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      to_sag_ff <= 1'b0;
    end else if (zc_any) begin
      to_sag_ff <= 1'b0;
    end else if (to_hit) begin
      to_sag_ff <= 1'b1;
    end
  end

  // Period timebase: eight clocks per unit, saturating
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      unit_div_ff <= 3'h0;
      unit_cnt_ff <= 16'h0000;
    end else if (zc_rise) begin
      unit_div_ff <= 3'h1; // Crossing clock opens the first unit
      unit_cnt_ff <= 16'h0000;
    end else begin
      unit_div_ff <= unit_div_ff + 3'h1;
      if (unit_div_ff == 3'(`LVS_PERIOD_UNIT_CLKS - 1) && unit_cnt_ff != `LVS_PERIOD_MAX) begin
        unit_cnt_ff <= unit_cnt_ff + 16'h0001;
      end
    end
  end

  // First-order smoothing, gain one sixteenth, with fraction bits
  // Trades response speed for a steady reading on a stable line
  assign meas_acc = {unit_cnt_ff, 4'h0};
  assign nxt_per_acc = per_acc_ff + 20'($signed(meas_acc - per_acc_ff) >>> `LVS_PERIOD_FRAC); // Signed step

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      per_acc_ff <= 20'h00000;
      per_seeded_ff <= 1'b0;
      per_armed_ff <= 1'b0;
    end else if (zc_rise) begin
      per_armed_ff <= 1'b1;
      if (per_armed_ff) begin
        per_seeded_ff <= 1'b1;
        per_acc_ff <= per_seeded_ff ? {1'b0, nxt_per_acc[18:0]} : meas_acc;
      end
    end
  end

  // Settling timer restarts while no period is being measured
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !per_seeded_ff || to_sag_ff) begin
      settle_cnt_ff <= 32'h00000000;
      settled_ff <= 1'b0;
    end else if (settle_cnt_ff == 32'(SETTLE_CLKS - 1)) begin
      settled_ff <= 1'b1;
    end else begin
      settle_cnt_ff <= settle_cnt_ff + 32'h00000001;
    end
  end

  // Levels 0x00 and 0x01 both mean a zero level, never below
  assign lvl_eff = (sag_lvl_ff <= 8'h01) ? 8'h00 : sag_lvl_ff;
  assign samp_below = lvl_eff > mag_byte(samp_i);

  // A line cycle is judged at its closing positive crossing
  // Count reaching cycle length minus one marks the sag
  assign sag_event = zc_rise && !above_seen_ff && (sag_state_ff == lvs_pkg::LVS_SAG_WATCH)
                     && (sag_cyc_ff > 8'h01) && (below_cycles_ff + 8'h01 == sag_cyc_ff - 8'h01);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      above_seen_ff <= 1'b0;
    end else if (zc_rise) begin
      above_seen_ff <= samp_valid_i && !samp_below;
    end else if (samp_valid_i && !samp_below) begin
      above_seen_ff <= 1'b1;
    end
  end

  // Sag state machine
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sag_state_ff <= lvs_pkg::LVS_SAG_WATCH;
      below_cycles_ff <= 8'h00;
    end else begin
      case (sag_state_ff)
        lvs_pkg::LVS_SAG_WATCH: begin
          if (sag_event) begin
            sag_state_ff <= lvs_pkg::LVS_SAG_LOW;
            below_cycles_ff <= 8'h00;
          end else if (zc_rise) begin
            below_cycles_ff <= above_seen_ff ? 8'h00 : below_cycles_ff + 8'h01;
          end
        end
        lvs_pkg::LVS_SAG_LOW: begin
          if (samp_valid_i && !samp_below) begin
            sag_state_ff <= lvs_pkg::LVS_SAG_WATCH;
          end
        end
        default: begin
          sag_state_ff <= lvs_pkg::LVS_SAG_WATCH;
        end
      endcase
    end
  end

  // Sag pin: inactive state wins over the disable bit
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sag_n_ff <= 1'b1;
    end else begin
      sag_n_ff <= !(sup_sync_ff
                    || (!sag_dis && to_sag_ff)
                    || (!sag_dis && sag_state_ff == lvs_pkg::LVS_SAG_LOW));
    end
  end

  assign sag_n_o = sag_n_ff;

  // Flag sources, set regardless of the enable bits
  always_comb begin
    set_flags = 16'h0000;
    set_flags[`LVS_BIT_ZX] = zc_any;
    set_flags[`LVS_BIT_CROSSING_TIMEOUT_FLAG] = to_hit;
    set_flags[`LVS_BIT_SAG] = sag_event;
  end

  // Sticky flags; an event in the clearing cycle survives
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      status_ff <= 16'h0000;
    end else if (clr_read) begin
      status_ff <= set_flags;
    end else begin
      status_ff <= status_ff | set_flags;
    end
  end

  // Interrupt pin from enabled flags, released by the clearing read
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      irq_n_ff <= 1'b1;
    end else if (clr_read) begin
      irq_n_ff <= !(|(set_flags & irq_en_ff));
    end else begin
      irq_n_ff <= !(|((status_ff | set_flags) & irq_en_ff));
    end
  end

  assign irq_n_o = irq_n_ff;

endmodule

`default_nettype wire

// ==== lvs_regs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
//          for the line voltage supervisor.
// Assumes: Included by the supervisor top; definitions only.
// Notes:   Register offsets are word addresses of the serial port.
`ifndef LVS_REGS_SVH
`define LVS_REGS_SVH

// Register offsets
`define LVS_OFS_MODE 6'h09
`define LVS_OFS_IRQ_EN 6'h0A
`define LVS_OFS_STATUS 6'h0B
`define LVS_OFS_STATUS_CLR 6'h0C
`define LVS_OFS_TIMEOUT 6'h1D
`define LVS_OFS_SAG_CYC 6'h1E
`define LVS_OFS_SAG_LVL 6'h1F
`define LVS_OFS_PERIOD 6'h27

// Status and interrupt enable bit positions
`define LVS_BIT_SAG 1
`define LVS_BIT_CROSSING_TIMEOUT_FLAG 3
`define LVS_BIT_ZX 4
`define LVS_FLAG_MASK 16'h001A

// Mode register fields
`define LVS_MODE_SAG_DIS 3
`define LVS_MODE_SETTLED 15

// Reset values
`define LVS_RST_TIMEOUT 12'hFFF
`define LVS_RST_SAG_CYC 8'h04
`define LVS_RST_SAG_LVL 8'h00
`define LVS_RST_MODE 16'h0000
`define LVS_RST_IRQ_EN 16'h0000

// Timing counts
`define LVS_CLK_HZ 25000000
`define LVS_TO_TICK_CLKS 128
`define LVS_PERIOD_UNIT_CLKS 8
`define LVS_SETTLE_MS 1800
`define LVS_SETTLE_CLKS ((`LVS_CLK_HZ / 1000) * `LVS_SETTLE_MS)
`define LVS_PERIOD_MAX 16'h7FFF
`define LVS_PERIOD_FRAC 4

`endif

// ==== lvs_pkg.sv ====
// Purpose: Shared types of the line voltage supervisor.
// Assumes: Used with lvs_regs.svh for numeric constants.
// Notes:   Referenced by full scope, never imported.
package lvs_pkg;

  // Filtered line sample, signed
  typedef logic signed [15:0] lvs_sample_t;

  // Sag detector states
  typedef enum logic [1:0] {
    LVS_SAG_WATCH = 2'b00,
    LVS_SAG_LOW = 2'b01
  } lvs_sag_e;

endpackage

// ==== lvs_zc_detect.sv ====
// Purpose: Zero-crossing detector on the filtered line samples.
// Assumes: Samples arrive with a one-cycle valid strobe, same clock.
// Notes:   Zero counts as positive, so a crossing needs a true sign flip.
`timescale 1ns/100ps
`default_nettype none

module lvs_zc_detect (
  input wire logic core_clk_i,                 // Core clock
  input wire logic sys_rst_i,                  // Synchronous reset
  input wire logic samp_valid_i,               // New filtered sample
  input wire lvs_pkg::lvs_sample_t samp_i,     // Filtered sample
  output logic rise_o,                         // Positive crossing pulse
  output logic fall_o,                         // Negative crossing pulse
  output logic level_o                         // Zero-cross output level
);

  logic prev_neg_ff;
  logic primed_ff;
  logic rise_ff;
  logic fall_ff;
  logic level_ff;
  logic new_neg;

  assign new_neg = samp_i[15];

  // Remember sign of the last sample; first sample only primes
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prev_neg_ff <= 1'b0;
      primed_ff <= 1'b0;
    end else if (samp_valid_i) begin
      prev_neg_ff <= new_neg;
      primed_ff <= 1'b1;
    end
  end

  // Sign change between samples, direction from the new sign
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      rise_ff <= samp_valid_i && primed_ff && prev_neg_ff && !new_neg;
      fall_ff <= samp_valid_i && primed_ff && !prev_neg_ff && new_neg;
    end
  end

  // Output follows crossing direction
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      level_ff <= 1'b0;
    end else if (rise_ff) begin
      level_ff <= 1'b1;
    end else if (fall_ff) begin
      level_ff <= 1'b0;
    end
  end

  assign rise_o = rise_ff;
  assign fall_o = fall_ff;
  assign level_o = level_ff;

endmodule

`default_nettype wire

// ==== lvs_supervisor_asserts.sv ====
// Purpose: Port-level checks for the line voltage supervisor.
// Assumes: Bound to lvs_supervisor; sees only its ports.
// Notes:   Keeps a shadow of the interrupt enable register.
`timescale 1ns/100ps
`default_nettype none
`include "lvs_regs.svh"

module lvs_supervisor_asserts (
  input wire logic core_clk_i,             // Core clock
  input wire logic sys_rst_i,              // Synchronous reset
  input wire logic samp_valid_i,           // Sample strobe
  input wire lvs_pkg::lvs_sample_t samp_i, // Filtered sample
  input wire logic supply_low_i,           // Supply low
  input wire logic [5:0] reg_addr_i,       // Register address
  input wire logic reg_wr_i,               // Write strobe
  input wire logic reg_rd_i,               // Read strobe
  input wire logic [15:0] reg_wdata_i,     // Write data
  input wire logic [15:0] reg_rdata_o,     // Read data
  input wire logic reg_rvalid_o,           // Read valid
  input wire logic zero_cross_out_o,       // Zero-cross output
  input wire logic sag_n_o,                // Sag pin
  input wire logic irq_n_o,                // Interrupt pin
  input wire logic inactive_o              // Inactive state
);
  logic primed_ff;
  logic neg_ff;
  logic [15:0] irq_en_ff;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Sign of last sample; the first after reset only primes
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      primed_ff <= 1'b0;
      neg_ff <= 1'b0;
    end else if (samp_valid_i) begin
      primed_ff <= 1'b1;
      neg_ff <= samp_i[15];
    end
  end

  // Enable shadow, so an idle pin can be demanded
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      irq_en_ff <= 16'h0000;
    end else if (reg_wr_i && reg_addr_i == `LVS_OFS_IRQ_EN) begin
      irq_en_ff <= reg_wdata_i;
    end
  end

  AST_ZX_RISE: assert property (samp_valid_i && primed_ff && neg_ff && !samp_i[15] |-> ##2 zero_cross_out_o)
    else $error("zero-cross output missed a rise");
  AST_ZX_FALL: assert property (samp_valid_i && primed_ff && !neg_ff && samp_i[15] |-> ##2 !zero_cross_out_o)
    else $error("zero-cross output missed a fall");
  AST_ZX_CAUSE: assert property ($changed(zero_cross_out_o) |-> $past(samp_valid_i, 2))
    else $error("zero-cross output moved without a sample");
  AST_INACTIVE_ON: assert property (supply_low_i [*3] |-> inactive_o)
    else $error("inactive state not entered");
  AST_INACTIVE_OFF: assert property (!supply_low_i [*3] |-> !inactive_o)
    else $error("inactive state without low supply");
  AST_SAG_INACTIVE: assert property (inactive_o |=> !sag_n_o)
    else $error("sag pin high while inactive");
  AST_IRQ_MASKED: assert property ((irq_en_ff & `LVS_FLAG_MASK) == 16'h0000 &&
    ($past(irq_en_ff) & `LVS_FLAG_MASK) == 16'h0000 |-> irq_n_o)
    else $error("interrupt pin low with all flags masked");
  AST_RD_ANSWER: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read got no answer");
  AST_TIMEOUT_WIDTH: assert property (reg_rd_i && reg_addr_i == `LVS_OFS_TIMEOUT |=> reg_rdata_o[15:12] == 4'h0)
    else $error("timeout reload wider than twelve bits");
  AST_PERIOD_MSB: assert property (reg_rd_i && reg_addr_i == `LVS_OFS_PERIOD |=> !reg_rdata_o[15])
    else $error("period top bit set");

  // Main scenarios reached
  COV_ZX: cover property ($rose(zero_cross_out_o));
  COV_SAG: cover property ($fell(sag_n_o));
  COV_IRQ: cover property ($fell(irq_n_o));
  COV_INACTIVE: cover property ($rose(inactive_o));
endmodule

bind lvs_supervisor lvs_supervisor_asserts lvs_supervisor_asserts_i (.core_clk_i, .sys_rst_i, .samp_valid_i,
  .samp_i, .supply_low_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
  .zero_cross_out_o, .sag_n_o, .irq_n_o, .inactive_o);
`default_nettype wire

// ==== lvs_host_model.sv ====
// Purpose: Microcontroller side of the register port.
// Assumes: One-cycle strobes; answer one cycle after a read.
// Notes:   Write data is inverted once released, so stale data shows.
`timescale 1ns/100ps
`default_nettype none

module lvs_host_model (
  input wire logic core_clk_i,          // Core clock
  input wire logic [15:0] reg_rdata_i,  // Read data
  input wire logic reg_rvalid_i,        // Read valid
  output logic [5:0] reg_addr_o,        // Register address
  output logic reg_wr_o,                // Write strobe
  output logic reg_rd_o,                // Read strobe
  output logic [15:0] reg_wdata_o       // Write data
);
  // Idle port at time zero
  initial begin
    reg_addr_o = 6'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  // One-cycle write; data dropped after the taking edge
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
    reg_addr_o <= ~a;
    @(negedge core_clk_i);
  endtask

  // Read, also the clearing read at its own address; bounded wait
  task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge core_clk_i);
      if (reg_rvalid_i === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata_i;
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== tb_lvs_supervisor.sv ====
// Purpose: Self-checking bench for the line voltage supervisor.
// Assumes: 25 MHz clock; host model drives the register port.
// Notes:   Each sample slot is five clocks, which sets line period.
`timescale 1ns/100ps
`default_nettype none
`include "lvs_regs.svh"

module tb_lvs_supervisor;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic samp_valid_i = 1'b0;
  lvs_pkg::lvs_sample_t samp_i = 16'h0000;
  logic supply_low_i = 1'b0;
  logic [5:0] reg_addr_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [15:0] reg_wdata_i;
  logic [15:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic zero_cross_out_o;
  logic sag_n_o;
  logic irq_n_o;
  logic inactive_o;
  int n_fail = 0;
  int checks_done = 0;

  always #20 core_clk_i = ~core_clk_i;

  // Short settling time keeps the run small
  lvs_supervisor #(.SETTLE_CLKS(64)) lvs_supervisor_i (.core_clk_i, .sys_rst_i, .samp_valid_i, .samp_i,
    .supply_low_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
    .zero_cross_out_o, .sag_n_o, .irq_n_o, .inactive_o);
  lvs_host_model lvs_host_model_i (.core_clk_i, .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
    .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h want %h", $time, w, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    lvs_host_model_i.wr(a, d);
  endtask

  // Masked register read with a bounded wait for the answer
  task automatic rr(input logic [5:0] a, input logic [15:0] m, input logic [15:0] e, input string w);
    logic [15:0] d;
    logic ok;
    lvs_host_model_i.rd(a, d, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t no read answer", $time);
      test_done();
    end else begin
      chk(d & m, e, w);
    end
  endtask

  // One sample slot of five clocks; stale value inverted after the strobe
  task automatic smp(input logic [15:0] v);
    @(posedge core_clk_i);
    samp_valid_i <= 1'b1;
    samp_i <= v;
    @(posedge core_clk_i);
    samp_valid_i <= 1'b0;
    samp_i <= ~v;
    repeat (3) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask

  task automatic t_reset();
    chk(zero_cross_out_o, 16'h0000, "zx idle");
    chk(sag_n_o, 16'h0001, "sag idle");
    chk(irq_n_o, 16'h0001, "irq idle");
    rr(`LVS_OFS_TIMEOUT, 16'hFFFF, 16'h0FFF, "timeout reset");
    wr(`LVS_OFS_TIMEOUT, 16'hF123);
    rr(`LVS_OFS_TIMEOUT, 16'hFFFF, 16'h0123, "timeout rw");
    rr(6'h3F, 16'hFFFF, 16'h0000, "unmapped read");
    wr(`LVS_OFS_TIMEOUT, 16'h0FFF);
    $display("t_reset done");
  endtask

  // 160 slots per cycle: 800 clocks, 100 eight-clock units
  task automatic t_period();
    logic [15:0] d;
    logic ok;
    smp(16'hD000);
    for (int k = 0; k < 3; k++) begin
      repeat (80) smp(16'h3000);
      repeat (80) smp(16'hD000);
    end
    lvs_host_model_i.rd(`LVS_OFS_PERIOD, d, ok);
    checks_done++;
    if (ok !== 1'b1 || $isunknown(d) || d > 16'h0065 || d < 16'h0063) begin
      n_fail++;
      $display("[ERR] %0t period %h", $time, d);
    end
    rr(`LVS_OFS_MODE, 16'h8000, 16'h8000, "settled");
    $display("t_period done");
  endtask

  task automatic t_sag();
    wr(`LVS_OFS_SAG_LVL, 16'h0020);
    wr(`LVS_OFS_SAG_CYC, 16'h0004);
    wr(`LVS_OFS_IRQ_EN, 16'h0002);
    smp(16'h3000);
    rr(`LVS_OFS_STATUS_CLR, 16'h0000, 16'h0000, "pre-clear");
    for (int n = 1; n <= 3; n++) begin
      smp(16'hFF00);
      smp(16'h0100);
      chk(sag_n_o, (n == 3) ? 16'h0000 : 16'h0001, "sag pin count");
    end
    chk(irq_n_o, 16'h0000, "sag irq");
    rr(`LVS_OFS_STATUS_CLR, 16'h0002, 16'h0002, "sag flag");
    chk(irq_n_o, 16'h0001, "irq after clear");
    smp(16'h3000);
    chk(sag_n_o, 16'h0001, "sag release");
    wr(`LVS_OFS_SAG_LVL, 16'h0001);
    repeat (4) begin
      smp(16'hFFC0);
      smp(16'h0040);
    end
    chk(sag_n_o, 16'h0001, "zero level");
    wr(`LVS_OFS_IRQ_EN, 16'h0000);
    $display("t_sag done");
  endtask

  task automatic t_zc();
    wr(`LVS_OFS_IRQ_EN, 16'h0010);
    rr(`LVS_OFS_STATUS_CLR, 16'h0000, 16'h0000, "pre-clear");
    smp(16'hFFFD);
    chk(zero_cross_out_o, 16'h0000, "zx fall");
    chk(irq_n_o, 16'h0000, "zx irq");
    rr(`LVS_OFS_STATUS_CLR, 16'h0010, 16'h0010, "zx flag fall");
    chk(irq_n_o, 16'h0001, "irq cleared");
    smp(16'h0000);
    chk(zero_cross_out_o, 16'h0001, "zx rise");
    rr(`LVS_OFS_STATUS, 16'h0010, 16'h0010, "zx flag held");
    rr(`LVS_OFS_STATUS_CLR, 16'h0010, 16'h0010, "zx flag rise");
    rr(`LVS_OFS_STATUS, 16'h0010, 16'h0000, "zx flag cleared");
    wr(`LVS_OFS_IRQ_EN, 16'h0000);
    $display("t_zc done");
  endtask

  // Reload of 2 expires between 128 and 257 clocks after a crossing
  task automatic t_timeout();
    wr(`LVS_OFS_TIMEOUT, 16'h0002);
    smp(16'hD000);
    rr(`LVS_OFS_STATUS_CLR, 16'h0000, 16'h0000, "pre-clear");
    cyc(100);
    rr(`LVS_OFS_STATUS, 16'h0008, 16'h0000, "no early timeout");
    chk(sag_n_o, 16'h0001, "sag before timeout");
    cyc(200);
    rr(`LVS_OFS_STATUS, 16'h0008, 16'h0008, "timeout flag");
    chk(sag_n_o, 16'h0000, "timeout sag");
    chk(irq_n_o, 16'h0001, "timeout masked");
    wr(`LVS_OFS_TIMEOUT, 16'h0FFF);
    smp(16'h3000);
    chk(sag_n_o, 16'h0001, "crossing releases");
    $display("t_timeout done");
  endtask

  task automatic t_inactive();
    wr(`LVS_OFS_MODE, 16'h0008);
    @(posedge core_clk_i);
    supply_low_i <= 1'b1;
    cyc(4);
    chk(inactive_o, 16'h0001, "inactive");
    chk(sag_n_o, 16'h0000, "sag inactive");
    @(posedge core_clk_i);
    supply_low_i <= 1'b0;
    cyc(4);
    chk(inactive_o, 16'h0000, "active again");
    wr(`LVS_OFS_MODE, 16'h0000);
    $display("t_inactive done");
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(negedge core_clk_i);
    t_reset();
    t_period();
    t_sag();
    t_zc();
    t_timeout();
    t_inactive();
    test_done();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk_i);
    n_fail++;
    $display("[ERR] %0t run limit reached", $time);
    test_done();
  end
endmodule
`default_nettype wire
